// ===== core/mct_edge.sv
// Purpose: Three-flop synchroniser with selectable edge detection.
// Assumes: Input is asynchronous to CLK.
// Notes:   First flop feeds only the second.
`timescale 1ns/1ps
module mct_edge
  import mct_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       pin,
  input  wire logic [1:0] sel,
  output logic            hit
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic rise;
  logic fall;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Accept a new level only once both later stages agree
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall = (s2_q == s3_q) && !s3_q && lvl_q;

  always_comb begin
    case (sel)
      MCT_EDGE_RISE: hit = rise;
      MCT_EDGE_FALL: hit = fall;
      MCT_EDGE_BOTH: hit = rise | fall;
      default:       hit = 1'b0;
    endcase
  end
endmodule : mct_edge

// ===== core/mct_pkg.sv
// Purpose: Shared constants for the match/capture timer.
// Assumes: 32-bit register port, word indices as addresses.
// Notes:   Offsets are register indices on the plain port.
package mct_pkg;
  localparam int          MCT_W        = 32;
  localparam int          MCT_NMATCH   = 4;
  localparam int          MCT_NCAP     = 2;
  localparam logic [4:0]  MCT_A_CTRL   = 5'h00;
  localparam logic [4:0]  MCT_A_COUNT  = 5'h01;
  localparam logic [4:0]  MCT_A_PRE_LIM = 5'h02;
  localparam logic [4:0]  MCT_A_PRE_CNT = 5'h03;
  localparam logic [4:0]  MCT_A_MCTL   = 5'h04;
  localparam logic [4:0]  MCT_A_CCTL   = 5'h05;
  localparam logic [4:0]  MCT_A_IRQ_ST = 5'h06;
  localparam logic [4:0]  MCT_A_IRQ_MSK = 5'h07;
  localparam logic [4:0]  MCT_A_MATCH0 = 5'h08;
  localparam logic [4:0]  MCT_A_CAP0   = 5'h0C;
  localparam logic [4:0]  MCT_A_OUTS   = 5'h0E;
  // CTRL: bit0 run, bit1 counter mode, bits3:2 count edge, bit4 count source (1 = capture pin 0)
  localparam int          MCT_CTRL_RUN = 0;
  localparam int          MCT_CTRL_CNT = 1;
  localparam int          MCT_CTRL_EDG = 2;
  localparam int          MCT_CTRL_SRC = 4;
  // CCTL per capture: bits[4c+1:4c] edge, bit 4c+2 clear-on-capture
  localparam int          MCT_CC_CLR   = 2;
  // MCTL per match: bit 8m+0 stop, +1 reset, bits +3:+2 output action
  localparam int          MCT_MC_STOP  = 0;
  localparam int          MCT_MC_RST   = 1;
  localparam int          MCT_MC_OUT   = 2;
  localparam logic [1:0]  MCT_EDGE_NONE = 2'h0;
  localparam logic [1:0]  MCT_EDGE_RISE = 2'h1;
  localparam logic [1:0]  MCT_EDGE_FALL = 2'h2;
  localparam logic [1:0]  MCT_EDGE_BOTH = 2'h3;
  localparam logic [1:0]  MCT_OUT_KEEP = 2'h0;
  localparam logic [1:0]  MCT_OUT_LOW  = 2'h1;
  localparam logic [1:0]  MCT_OUT_HIGH = 2'h2;
  localparam logic [1:0]  MCT_OUT_TOG  = 2'h3;
  localparam logic [31:0] MCT_RST_ZERO = 32'h0000_0000;
endpackage : mct_pkg

// ===== core/mct_timer.sv
// Purpose: Match/capture counter-timer with plain register port.
// Assumes: Pins asynchronous; software port synchronous to CLK.
// Notes:   Width parameter W is 32 or 16 per instance.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module mct_timer
  import mct_pkg::*;
#(
  parameter int W = MCT_W
)(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [4:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        COUNT_PIN,
  input  wire logic [1:0]  CAP_PIN,
  output logic      [3:0]  MATCH_OUT,
  output logic             IRQ
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [4:0]   ctrl_q;
  logic [W-1:0] count_q;
  logic [W-1:0] pre_lim_q;
  logic [W-1:0] pre_cnt_q;
  logic [31:0]  mctl_q;
  logic [7:0]   cctl_q;
  logic [5:0]   irq_st_q;
  logic [5:0]   irq_msk_q;
  logic [W-1:0] match_q [MCT_NMATCH];
  logic [W-1:0] cap_q   [MCT_NCAP];
  logic [3:0]   out_q;
  logic [31:0]  rdata_q;
  logic         irq_q;

  logic         cnt_edge;
  logic [1:0]   cap_hit;
  logic [3:0]   m_hit;
  logic         tick;
  logic         pre_wrap;
  logic         any_stop;
  logic         any_rst;
  logic         cap_clr;
  logic         wr_ctrl;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  mct_edge u_cnt (
    .clk     (CLK),
    .reset_n (RESET_N),
    .pin     (COUNT_PIN),
    .sel     (ctrl_q[MCT_CTRL_EDG +: 2]),
    .hit     (cnt_edge)
  );

  genvar gc;
  generate
    for (gc = 0; gc < MCT_NCAP; gc++) begin : g_cap
      mct_edge u_cap (
        .clk     (CLK),
        .reset_n (RESET_N),
        .pin     (CAP_PIN[gc]),
        .sel     (cctl_q[4*gc +: 2]),
        .hit     (cap_hit[gc])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Count engine
  // ------------------------------------------------------------
  // Counter mode may instead count a capture pin when SRC is set
  logic ext_evt;
  assign ext_evt = ctrl_q[MCT_CTRL_SRC] ? cap_hit[0] : cnt_edge;

  assign pre_wrap = (pre_cnt_q == pre_lim_q);
  always_comb begin
    if (!ctrl_q[MCT_CTRL_RUN]) begin
      tick = 1'b0;
    end else if (ctrl_q[MCT_CTRL_CNT]) begin
      tick = ext_evt;
    end else begin
      tick = pre_wrap;
    end
  end

  always_comb begin
    m_hit    = 4'h0;
    any_stop = 1'b0;
    any_rst  = 1'b0;
    for (int m = 0; m < MCT_NMATCH; m++) begin
      // Match acts as the count reaches the value on a tick
      m_hit[m] = tick && (count_q + W'(1) == match_q[m]);
      any_stop |= m_hit[m] && mctl_q[8*m + MCT_MC_STOP];
      any_rst  |= m_hit[m] && mctl_q[8*m + MCT_MC_RST];
    end
  end

  always_comb begin
    cap_clr = 1'b0;
    for (int c = 0; c < MCT_NCAP; c++) begin
      cap_clr |= cap_hit[c] && cctl_q[4*c + MCT_CC_CLR];
    end
  end

  assign wr_ctrl = WR && (ADDR == MCT_A_CTRL);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= 5'h00;
    end else if (wr_ctrl) begin
      ctrl_q <= WDATA[4:0];
    end else if (any_stop) begin
      ctrl_q[MCT_CTRL_RUN] <= 1'b0;
    end
  end

  // prescaler and counter both W bits
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pre_cnt_q <= W'(MCT_RST_ZERO);
    end else if (cap_clr) begin
      pre_cnt_q <= '0;
    end else if (WR && ADDR == MCT_A_PRE_CNT) begin
      pre_cnt_q <= WDATA[W-1:0];
    end else if (ctrl_q[MCT_CTRL_RUN] && !ctrl_q[MCT_CTRL_CNT]) begin
      pre_cnt_q <= pre_wrap ? '0 : pre_cnt_q + W'(1);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_q <= W'(MCT_RST_ZERO);
    end else if (cap_clr) begin
      count_q <= '0;
    end else if (WR && ADDR == MCT_A_COUNT) begin
      count_q <= WDATA[W-1:0];
    end else if (tick) begin
      // Stop holds the matched value; reset wins over stop
      count_q <= any_rst ? '0 : count_q + W'(1);
    end
  end

  // ------------------------------------------------------------
  // Match and capture registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pre_lim_q <= W'(MCT_RST_ZERO);
      mctl_q    <= MCT_RST_ZERO;
      cctl_q    <= 8'h00;
      irq_msk_q <= 6'h00;
      for (int m = 0; m < MCT_NMATCH; m++) begin
        match_q[m] <= W'(MCT_RST_ZERO);
      end
    end else if (WR) begin
      case (ADDR)
        MCT_A_PRE_LIM: pre_lim_q <= WDATA[W-1:0];
        MCT_A_MCTL:    mctl_q    <= WDATA;
        MCT_A_CCTL:    cctl_q    <= WDATA[7:0];
        MCT_A_IRQ_MSK: irq_msk_q <= WDATA[5:0];
        default: begin
          for (int m = 0; m < MCT_NMATCH; m++) begin
            if (ADDR == MCT_A_MATCH0 + 5'(m)) begin
              match_q[m] <= WDATA[W-1:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int c = 0; c < MCT_NCAP; c++) begin
        cap_q[c] <= W'(MCT_RST_ZERO);
      end
    end else begin
      for (int c = 0; c < MCT_NCAP; c++) begin
        if (cap_hit[c]) begin
          cap_q[c] <= count_q;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Match outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_q <= 4'h0;
    end else begin
      for (int m = 0; m < MCT_NMATCH; m++) begin
        if (WR && ADDR == MCT_A_OUTS) begin
          out_q[m] <= WDATA[m];
        end else if (m_hit[m]) begin
          case (mctl_q[8*m + MCT_MC_OUT +: 2])
            MCT_OUT_LOW:  out_q[m] <= 1'b0;
            MCT_OUT_HIGH: out_q[m] <= 1'b1;
            MCT_OUT_TOG:  out_q[m] <= ~out_q[m];
            default:      out_q[m] <= out_q[m];
          endcase
        end
      end
    end
  end
  assign MATCH_OUT = out_q;

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  // Bits 3:0 match flags, 5:4 capture flags; a new event beats a clear
  logic [5:0] evt;
  logic [5:0] irq_st_d;
  logic [5:0] irq_msk_d;
  assign evt = {cap_hit, m_hit};
  assign irq_st_d  = ((WR && ADDR == MCT_A_IRQ_ST) ?
                      (irq_st_q & ~WDATA[5:0]) : irq_st_q) | evt;
  // IRQ uses next status and next mask so it never lags a mask write
  assign irq_msk_d = (WR && ADDR == MCT_A_IRQ_MSK) ? WDATA[5:0] : irq_msk_q;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_st_q <= 6'h00;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_d & irq_msk_d);
    end
  end
  assign IRQ = irq_q;

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        MCT_A_CTRL:    rdata_q <= 32'(ctrl_q);
        MCT_A_COUNT:   rdata_q <= 32'(count_q);
        MCT_A_PRE_LIM: rdata_q <= 32'(pre_lim_q);
        MCT_A_PRE_CNT: rdata_q <= 32'(pre_cnt_q);
        MCT_A_MCTL:    rdata_q <= mctl_q;
        MCT_A_CCTL:    rdata_q <= 32'(cctl_q);
        MCT_A_IRQ_ST:  rdata_q <= 32'(irq_st_q);
        MCT_A_IRQ_MSK: rdata_q <= 32'(irq_msk_q);
        MCT_A_MATCH0:  rdata_q <= 32'(match_q[0]);
        5'h09:         rdata_q <= 32'(match_q[1]);
        5'h0A:         rdata_q <= 32'(match_q[2]);
        5'h0B:         rdata_q <= 32'(match_q[3]);
        MCT_A_CAP0:    rdata_q <= 32'(cap_q[0]);
        5'h0D:         rdata_q <= 32'(cap_q[1]);
        MCT_A_OUTS:    rdata_q <= 32'(out_q);
        default:       rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign RDATA = rdata_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_match_hit(int m);
    m_hit[m] && !cap_clr && !(WR && ADDR == MCT_A_COUNT);
  endsequence

  property p_prewrap;
    @(posedge CLK) disable iff (!RESET_N)
    (ctrl_q[0] && !ctrl_q[1] && pre_wrap && !cap_clr &&
     !(WR && ADDR == MCT_A_PRE_CNT)) |=> (pre_cnt_q == '0);
  endproperty
  a_prewrap: assert property (p_prewrap)
    else $error("prescaler did not wrap");

  property p_tick;
    @(posedge CLK) disable iff (!RESET_N)
    (tick && !any_rst && !cap_clr && !(WR && ADDR == MCT_A_COUNT))
      |=> (count_q == $past(count_q) + W'(1));
  endproperty
  a_tick: assert property (p_tick)
    else $error("count did not advance on tick");

  property p_hold;
    @(posedge CLK) disable iff (!RESET_N)
    (!tick && !cap_clr && !(WR && ADDR == MCT_A_COUNT)) |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved without tick");

  property p_rst;
    @(posedge CLK) disable iff (!RESET_N)
    (s_match_hit(1) and (mctl_q[8 + MCT_MC_RST] == 1'b1)) |=> (count_q == '0);
  endproperty
  a_rst: assert property (p_rst)
    else $error("match reset failed");

  property p_stop;
    @(posedge CLK) disable iff (!RESET_N)
    (m_hit[0] && mctl_q[MCT_MC_STOP] && !wr_ctrl) |=> !ctrl_q[MCT_CTRL_RUN];
  endproperty
  a_stop: assert property (p_stop)
    else $error("match stop failed");

  property p_cap;
    @(posedge CLK) disable iff (!RESET_N)
    cap_hit[1] |=> (cap_q[1] == $past(count_q));
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture value wrong");

  property p_capclr;
    @(posedge CLK) disable iff (!RESET_N)
    cap_clr |=> (count_q == '0 && pre_cnt_q == '0);
  endproperty
  a_capclr: assert property (p_capclr)
    else $error("capture clear failed");

  property p_flag;
    @(posedge CLK) disable iff (!RESET_N)
    m_hit[1] |=> irq_st_q[1];
  endproperty
  a_flag: assert property (p_flag)
    else $error("match flag lost");

  property p_irq;
    @(posedge CLK) disable iff (!RESET_N)
    ##1 (IRQ == |(irq_st_q & irq_msk_q));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq line mismatch");

  property p_tog;
    @(posedge CLK) disable iff (!RESET_N)
    (m_hit[2] && mctl_q[16 + MCT_MC_OUT +: 2] == MCT_OUT_TOG &&
     !(WR && ADDR == MCT_A_OUTS)) |=> (out_q[2] != $past(out_q[2]));
  endproperty
  a_tog: assert property (p_tog)
    else $error("toggle output failed");
endmodule : mct_timer

// ===== test/mct_pins.sv
// Purpose: Far-side model of the timer's count, capture and match pins.
// Assumes: Bench asks for pin levels; the model moves them off the clock.
// Notes:   Counts rising edges of match output 1 for toggle checks.
`timescale 1ns/1ps
module mct_pins (
  input  wire logic       clk,
  input  wire logic [1:0] cap_lvl,
  input  wire logic       cnt_lvl,
  output logic      [1:0] cap_pin,
  output logic            count_pin,
  input  wire logic [3:0] match_out,
  output int              rises
);
  initial begin
    cap_pin   = 2'h0;
    count_pin = 1'b0;
    rises     = 0;
  end
  // Pins are asynchronous: move them 7 ns after each rising edge to exercise the sync flops
  always @(posedge clk) begin
    #7;
    cap_pin   = cap_lvl;
    count_pin = cnt_lvl;
  end
  always @(posedge match_out[1]) begin
    rises++;
  end
endmodule : mct_pins

// ===== test/tb_mct_timer.sv
// Purpose: Self-checking bench for the match/capture timer.
// Assumes: 32-bit instance; one-cycle read latency on the plain port.
// Notes:   Event timings are checked with margin for pin synchronisers.
`timescale 1ns/1ps
module tb_mct_timer;
  import mct_pkg::*;
  logic        clk;
  logic        reset_n;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [31:0] rdata;
  logic [1:0]  cap_pin;
  logic        count_pin;
  logic [3:0]  match_out;
  logic        irq;
  logic [1:0]  cap_lvl;
  logic        cnt_lvl;
  int          rises;
  int          err_count;
  int          num_checks;
  int          r0;
  logic [31:0] v;
  logic [4:0]  ra [9] = '{MCT_A_PRE_LIM, MCT_A_PRE_CNT, MCT_A_MATCH0, 5'h09,
                          5'h0A, 5'h0B, MCT_A_CAP0, MCT_A_OUTS, 5'h1F};
  logic [31:0] rw [9] = '{32'h3, 32'h2, 32'hFFFF_FF00, 32'hFFFF_FF01,
                          32'hFFFF_FF02, 32'hFFFF_FF03, 32'hDEAD_BEEF,
                          32'h5, 32'h5A5A_5A5A};
  logic [31:0] rx [9] = '{32'h3, 32'h2, 32'hFFFF_FF00, 32'hFFFF_FF01,
                          32'hFFFF_FF02, 32'hFFFF_FF03, 32'h0, 32'h5, 32'h0};

  mct_timer #(.W(32)) i_mct_timer (
    .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .COUNT_PIN(count_pin), .CAP_PIN(cap_pin),
    .MATCH_OUT(match_out), .IRQ(irq)
  );
  mct_pins i_mct_pins (
    .clk(clk), .cap_lvl(cap_lvl), .cnt_lvl(cnt_lvl), .cap_pin(cap_pin),
    .count_pin(count_pin), .match_out(match_out), .rises(rises)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe; sample mid-cycle
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_c(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_c

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    wait_c(20000);
    err_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0; addr = 5'h0; wdata = 32'h0; wr_s = 1'b0; rd_s = 1'b0;
    cap_lvl = 2'h0; cnt_lvl = 1'b0; err_count = 0; num_checks = 0;
    wait_c(6);
    reset_n <= 1'b1;
    rd(MCT_A_CTRL, v); chk(v, 32'h0);
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i], v); chk(v, rx[i]);
    end
    // Prescaled run that stops on match 0
    wr(MCT_A_MATCH0, 32'h5); wr(MCT_A_MCTL, 32'h1); wr(MCT_A_CTRL, 32'h1);
    wait_c(10);
    rd(MCT_A_COUNT, v);
    chk({31'h0, v >= 1 && v <= 3}, 32'h1);
    wait_c(50);
    rd(MCT_A_COUNT, v); chk(v, 32'h5);
    rd(MCT_A_CTRL, v); chk(v & 32'h1, 32'h0);
    rd(MCT_A_IRQ_ST, v); chk(v & 32'h1, 32'h1);
    // Every output action on match 2, which also stops the count at 4
    for (int k = 0; k < 4; k++) begin
      wr(MCT_A_CTRL, 32'h0); wr(MCT_A_COUNT, 32'h0);
      wr(MCT_A_OUTS, (k < 2) ? 32'h4 : 32'h0);
      wr(MCT_A_MCTL, (32'(k) << 18) | 32'h1_0000);
      wr(5'h0A, 32'h4); wr(MCT_A_CTRL, 32'h1);
      wait_c(40);
      chk({31'h0, match_out[2]}, {31'h0, k == 0 || k >= 2});
      rd(MCT_A_COUNT, v); chk(v, 32'h4);
    end
    // Match 3 only flags; match 2 stops later at 6
    wr(MCT_A_CTRL, 32'h0); wr(MCT_A_COUNT, 32'h0); wr(MCT_A_IRQ_MSK, 32'h0);
    wr(MCT_A_IRQ_ST, 32'h3F); wr(5'h0B, 32'h2); wr(5'h0A, 32'h6);
    wr(MCT_A_MCTL, 32'h1_0000); wr(MCT_A_CTRL, 32'h1);
    wait_c(50);
    rd(MCT_A_COUNT, v); chk(v, 32'h6);
    rd(MCT_A_IRQ_ST, v); chk(v & 32'hC, 32'hC);
    chk({31'h0, irq}, 32'h0);
    wr(MCT_A_IRQ_MSK, 32'h8); wait_c(2);
    chk({31'h0, irq}, 32'h1);
    wr(MCT_A_IRQ_ST, 32'h8); wait_c(2);
    chk({31'h0, irq}, 32'h0);
    // Match 1 resets the count at 3 and toggles its output each time
    wr(MCT_A_CTRL, 32'h0); wr(MCT_A_COUNT, 32'h0); wr(MCT_A_PRE_LIM, 32'h0);
    wr(5'h09, 32'h3); wr(MCT_A_MCTL, 32'hE00);
    r0 = rises;
    wr(MCT_A_CTRL, 32'h1);
    wait_c(60);
    rd(MCT_A_COUNT, v); chk({31'h0, v < 3}, 32'h1);
    chk({31'h0, rises - r0 >= 8 && rises - r0 <= 12}, 32'h1);
    // Counter mode on rising edges of the count pin
    wr(MCT_A_CTRL, 32'h0); wr(MCT_A_COUNT, 32'h0); wr(MCT_A_MCTL, 32'h0);
    wr(5'h09, 32'hFFFF_0000); wr(MCT_A_CTRL, 32'h7);
    for (int n = 0; n < 3; n++) begin
      cnt_lvl <= 1'b1; wait_c(6);
      cnt_lvl <= 1'b0; wait_c(6);
    end
    rd(MCT_A_COUNT, v); chk(v, 32'h3);
    // Counter mode fed by capture pin 0 on both of its edges
    wr(MCT_A_CTRL, 32'h0); wr(MCT_A_COUNT, 32'h0); wr(MCT_A_CCTL, 32'h3);
    wr(MCT_A_CTRL, 32'h13);
    cap_lvl <= 2'h1; wait_c(6);
    cap_lvl <= 2'h0; wait_c(6);
    rd(MCT_A_COUNT, v); chk(v, 32'h2);
    // Each capture edge selection, with the capture 0 interrupt unmasked
    wr(MCT_A_CTRL, 32'h1); wr(MCT_A_IRQ_MSK, 32'h10);
    for (int s = 0; s < 4; s++) begin
      wr(MCT_A_CCTL, 32'(s)); wr(MCT_A_IRQ_ST, 32'h3F);
      cap_lvl <= 2'h1; wait_c(8);
      rd(MCT_A_IRQ_ST, v);
      chk(v & 32'h10, (s % 2) ? 32'h10 : 32'h0);
      chk({31'h0, irq}, {31'h0, s % 2 == 1});
      wr(MCT_A_IRQ_ST, 32'h3F);
      cap_lvl <= 2'h0; wait_c(8);
      rd(MCT_A_IRQ_ST, v);
      chk(v & 32'h10, (s >= 2) ? 32'h10 : 32'h0);
    end
    rd(MCT_A_CAP0, v); chk({31'h0, v != 0}, 32'h1);
    // Capture 1 clears counter and prescaler; its interrupt stays masked
    wr(MCT_A_PRE_LIM, 32'h7); wr(MCT_A_CCTL, 32'h50);
    wr(MCT_A_IRQ_ST, 32'h3F);
    wait_c(100);
    cap_lvl <= 2'h2; wait_c(6);
    rd(MCT_A_COUNT, v); chk(v, 32'h0);
    rd(MCT_A_IRQ_ST, v); chk(v & 32'h20, 32'h20);
    chk({31'h0, irq}, 32'h0);
    rd(MCT_A_CAP0 + 5'h1, v); chk({31'h0, v >= 32'hB}, 32'h1);
    // Reset in mid-run drops every output
    wr(MCT_A_IRQ_MSK, 32'h20); wr(MCT_A_OUTS, 32'hF); wait_c(2);
    chk({31'h0, irq}, 32'h1);
    reset_n <= 1'b0; wait_c(2);
    chk({27'h0, irq, match_out}, 32'h0);
    reset_n <= 1'b1;
    rd(MCT_A_CTRL, v); chk(v, 32'h0);
    rd(MCT_A_COUNT, v); chk(v, 32'h0);
    end_of_test();
  end
endmodule : tb_mct_timer
